// ===== epl_loader.v
/*
 * Port configuration loader: reads eight preload words from the serial
 * configuration store and drives the mapped per-port configuration fields.
 * Assumes a word reader on mclk (request/valid handshake) and an APB master.
 */
//
// Contract
// - Port 3 no-soft-reset bit comes from bit 0 of word 56h.
// - Port 3 power-management capability fields come from word 56h bits 7:1.
// - Word bits 3:1 fill the auxiliary-current field.
// - Word bit 4 reports D1 power-state support.
// - Word bit 5 reports D2 power-state support.
// - Word bits 7:6 advertise PME support from D2 and D1.
// - Data word bits 15:8 become the read-only PM data byte.
// - PM data bytes come from words 57h, 59h and 5Bh for ports 3-5.
// - Port 4 capability bits come from word 58h, same layout.
// - Port 5 capability bits come from word 5Ah, same layout.
// - Port 0 slot clock comes from word 60h bit 1.
// - Word bit 2 sets device-specific initialization required.
// - Word bit 3 counts VC1 as low-priority virtual channel.
// - Word bits 6:4 give the logical port number.
// - Word bits 15:9 map traffic classes 7:1 onto VC0.
// - Port 1 slot-implemented comes from word 62h bit 0.
// - Port 1 capability fields come from word 62h, port 0 positions.
// - Port 0 has no slot-implemented bit; word 60h bit 0 unused.
`timescale 1ns/1ps
`include "epl_defines.vh"

module epl_loader (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ce,
    // Preload word reader
    output reg         ee_req,
    output reg  [7:0]  ee_addr,
    input  wire        ee_valid,
    input  wire        ee_err,
    input  wire [15:0] ee_data,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // Configuration access gate
    output reg         cfg_ready,
    // Ports 3..5, index 0 is port 3
    output reg  [2:0]  pm_no_soft_reset,
    output reg  [8:0]  pm_aux_current,
    output reg  [2:0]  pm_d1_support,
    output reg  [2:0]  pm_d2_support,
    output reg  [5:0]  pm_pme_support,
    output reg  [23:0] pm_data,
    // Ports 0..1, index 0 is port 0
    output reg  [1:0]  pc_slot_clock,
    output reg  [1:0]  pc_dsi,
    output reg  [1:0]  pc_lpvc,
    output reg  [5:0]  pc_port_num,
    output reg  [13:0] pc_vc0_map,
    output reg         pc1_slot_impl
);

    localparam ST_IDLE = 2'b00;
    localparam ST_REQ  = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ST_DONE = 2'b11;

    reg [1:0]  state;
    reg [2:0]  idx;
    reg        auto_load;
    reg        reload_req;
    reg        load_err;
    reg        boot;
    reg [15:0] last_word;

    // Fixed order of source words
    function [7:0] word_addr;
        input [2:0] i;
        begin
            case (i)
                3'h0:    word_addr = `EPL_W_P3_CAP;
                3'h1:    word_addr = `EPL_W_P3_DATA;
                3'h2:    word_addr = `EPL_W_P4_CAP;
                3'h3:    word_addr = `EPL_W_P4_DATA;
                3'h4:    word_addr = `EPL_W_P5_CAP;
                3'h5:    word_addr = `EPL_W_P5_DATA;
                3'h6:    word_addr = `EPL_W_P0_SLOT;
                default: word_addr = `EPL_W_P1_SLOT;
            endcase
        end
    endfunction

    wire apb_setup = psel & ~penable;
    wire apb_acc   = psel & penable & ~pready;
    wire apb_wr    = apb_acc & pwrite;
    wire map_hit   = (paddr == `EPL_REG_CTRL) | (paddr == `EPL_REG_STATUS) |
                     (paddr == `EPL_REG_LASTWORD);
    wire reload_wr = apb_wr & (paddr == `EPL_REG_CTRL) & pwdata[`EPL_CTRL_RELOAD];
    wire word_in   = (state == ST_WAIT) & ee_valid;

    // Load sequencer
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state      <= ST_IDLE;
            idx        <= 3'h0;
            ee_req     <= 1'b0;
            ee_addr    <= 8'h00;
            cfg_ready  <= 1'b0;
            boot       <= 1'b1;
            reload_req <= 1'b0;
            load_err   <= 1'b0;
            last_word  <= 16'h0000;
        end else if (ce) begin
            // A reload asked for mid-load is kept for after it
            if (reload_wr)
                reload_req <= 1'b1;
            case (state)
                ST_IDLE: begin
                    if (boot | reload_req | reload_wr) begin
                        boot       <= 1'b0;
                        reload_req <= 1'b0;
                        load_err   <= 1'b0;
                        cfg_ready  <= 1'b0;
                        idx        <= 3'h0;
                        state      <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    ee_req  <= 1'b1;
                    ee_addr <= word_addr(idx);
                    state   <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (ee_valid) begin
                        ee_req    <= 1'b0;
                        last_word <= ee_data;
                        if (ee_err)
                            load_err <= 1'b1;
                        if (idx == `EPL_LAST_IDX) begin
                            state <= ST_DONE;
                        end else begin
                            idx   <= idx + 3'h1;
                            state <= ST_REQ;
                        end
                    end
                end
                ST_DONE: begin
                    // Gate opens only after the last field has landed
                    cfg_ready <= 1'b1;
                    state     <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Field capture, one word per handshake
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pm_no_soft_reset <= 3'h0;
            pm_aux_current   <= 9'h000;
            pm_d1_support    <= 3'h0;
            pm_d2_support    <= 3'h0;
            pm_pme_support   <= 6'h00;
            pm_data          <= 24'h00_0000;
            pc_slot_clock    <= 2'h0;
            pc_dsi           <= 2'h0;
            pc_lpvc          <= 2'h0;
            pc_port_num      <= 6'h00;
            pc_vc0_map       <= 14'h0000;
            pc1_slot_impl    <= 1'b0;
        end else if (ce & word_in & ~ee_err) begin
            // Corrupt words keep the previous field values
            case (idx)
                3'h0, 3'h2, 3'h4: begin
                    pm_no_soft_reset[idx[2:1]] <= ee_data[`EPL_B_NSR];
                    pm_aux_current[idx[2:1]*3 +: 3] <=
                        ee_data[`EPL_B_AUX_HI:`EPL_B_AUX_LO];
                    pm_d1_support[idx[2:1]] <= ee_data[`EPL_B_D1];
                    pm_d2_support[idx[2:1]] <= ee_data[`EPL_B_D2];
                    pm_pme_support[idx[2:1]*2 +: 2] <=
                        ee_data[`EPL_B_PME_HI:`EPL_B_PME_LO];
                end
                3'h1, 3'h3, 3'h5: begin
                    pm_data[idx[2:1]*8 +: 8] <=
                        ee_data[`EPL_B_DATA_HI:`EPL_B_DATA_LO];
                end
                3'h6, 3'h7: begin
                    pc_slot_clock[idx[0]] <= ee_data[`EPL_B_SLOT_CLK];
                    pc_dsi[idx[0]]        <= ee_data[`EPL_B_DSI];
                    pc_lpvc[idx[0]]       <= ee_data[`EPL_B_LPVC];
                    pc_port_num[idx[0]*3 +: 3] <=
                        ee_data[`EPL_B_PNUM_HI:`EPL_B_PNUM_LO];
                    pc_vc0_map[idx[0]*7 +: 7] <=
                        ee_data[`EPL_B_VC0_HI:`EPL_B_VC0_LO];
                    // Port 0 word carries no slot-implemented bit
                    if (idx[0])
                        pc1_slot_impl <= ee_data[`EPL_B_SLOT_IMPL];
                end
                default: pc1_slot_impl <= pc1_slot_impl;
            endcase
        end
    end

    // APB slave: answers in the second access cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready    <= 1'b0;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
            auto_load <= 1'b1;
        end else if (ce) begin
            pready  <= apb_acc;
            pslverr <= apb_acc & ~map_hit;
            if (apb_wr & (paddr == `EPL_REG_CTRL))
                auto_load <= pwdata[`EPL_CTRL_AUTO];
            if (apb_acc & ~pwrite) begin
                case (paddr)
                    `EPL_REG_CTRL:
                        prdata <= {30'h0, auto_load, 1'b0};
                    `EPL_REG_STATUS:
                        prdata <= {21'h0, idx, 5'h00, load_err,
                                   (state != ST_IDLE), cfg_ready};
                    `EPL_REG_LASTWORD:
                        prdata <= {16'h0000, last_word};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end else if (apb_setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule // epl_loader

// ===== epl_defines.vh
/*
 * Constants of the port configuration loader: source word addresses,
 * bit positions inside a source word, register offsets and reset values.
 * Assumes inclusion by bare name from the loader module.
 */
`ifndef EPL_DEFINES_VH
`define EPL_DEFINES_VH

// Source word addresses
`define EPL_W_P3_CAP      8'h56
`define EPL_W_P3_DATA     8'h57
`define EPL_W_P4_CAP      8'h58
`define EPL_W_P4_DATA     8'h59
`define EPL_W_P5_CAP      8'h5A
`define EPL_W_P5_DATA     8'h5B
`define EPL_W_P0_SLOT     8'h60
`define EPL_W_P1_SLOT     8'h62

// Power-management word layout
`define EPL_B_NSR         0
`define EPL_B_AUX_LO      1
`define EPL_B_AUX_HI      3
`define EPL_B_D1          4
`define EPL_B_D2          5
`define EPL_B_PME_LO      6
`define EPL_B_PME_HI      7
`define EPL_B_DATA_LO     8
`define EPL_B_DATA_HI     15

// Slot / capability word layout
`define EPL_B_SLOT_IMPL   0
`define EPL_B_SLOT_CLK    1
`define EPL_B_DSI         2
`define EPL_B_LPVC        3
`define EPL_B_PNUM_LO     4
`define EPL_B_PNUM_HI     6
`define EPL_B_VC0_LO      9
`define EPL_B_VC0_HI      15

// Load sequence
`define EPL_NUM_WORDS     4'h8
`define EPL_LAST_IDX      3'h7

// APB register offsets
`define EPL_REG_CTRL      12'h000
`define EPL_REG_STATUS    12'h004
`define EPL_REG_LASTWORD  12'h008

// Register bits
`define EPL_CTRL_RELOAD   0
`define EPL_CTRL_AUTO     1
`define EPL_ST_DONE       0
`define EPL_ST_BUSY       1
`define EPL_ST_ERR        2

// Reset values
`define EPL_CTRL_RESET    2'h2

`endif

// ===== epl_eeprom_model.sv
/*
 * Behavioural preload store on the far side of the word reader.
 * Assumes the bench fills mem by hierarchy before each load.
 */
`timescale 1ns/1ps
module epl_eeprom_model (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ee_req,
    input  wire [7:0]  ee_addr,
    input  wire [3:0]  slow,
    input  wire [7:0]  err_addr,
    output reg         ee_valid,
    output reg         ee_err,
    output reg  [15:0] ee_data
);
    reg [15:0] mem [0:255];
    reg [3:0]  cnt;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ee_valid <= 1'b0;
            ee_err   <= 1'b0;
            ee_data  <= 16'h0000;
            cnt      <= 4'h0;
        end else begin
            ee_valid <= 1'b0;
            ee_err   <= 1'b0;
            if (ee_req && !ee_valid && cnt >= slow) begin
                ee_valid <= 1'b1;
                ee_data  <= mem[ee_addr];
                ee_err   <= (ee_addr == err_addr);
                cnt      <= 4'h0;
            end else begin
                // Stale data must not look valid
                ee_data <= ~ee_data;
                if (ee_req && !ee_valid)
                    cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // epl_eeprom_model

// ===== epl_loader_chk.sv
/*
 * Checker for the port configuration loader.
 * Assumes it is bound to epl_loader and sees only its ports.
 */
`timescale 1ns/1ps
module epl_loader_chk (
    input wire        mclk,
    input wire        rst,
    input wire        ce,
    input wire        ee_req,
    input wire [7:0]  ee_addr,
    input wire        ee_valid,
    input wire        ee_err,
    input wire [15:0] ee_data,
    input wire        cfg_ready,
    input wire [2:0]  pm_no_soft_reset,
    input wire [8:0]  pm_aux_current,
    input wire [2:0]  pm_d1_support,
    input wire [2:0]  pm_d2_support,
    input wire [5:0]  pm_pme_support,
    input wire [23:0] pm_data,
    input wire [1:0]  pc_slot_clock,
    input wire [1:0]  pc_dsi,
    input wire [1:0]  pc_lpvc,
    input wire [5:0]  pc_port_num,
    input wire [13:0] pc_vc0_map,
    input wire        pc1_slot_impl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire ld = ee_req && ee_valid && !ee_err && ce;
    chk_p3_nsr: assert property (ld && ee_addr == 8'h56 |=>
        pm_no_soft_reset[0] == $past(ee_data[0])) else $error("port 3 nsr wrong");
    chk_p3_caps: assert property (ld && ee_addr == 8'h56 |=>
        {pm_pme_support[1:0], pm_d2_support[0], pm_d1_support[0], pm_aux_current[2:0]}
        == $past(ee_data[7:1])) else $error("port 3 caps wrong");
    chk_p3_data: assert property (ld && ee_addr == 8'h57 |=>
        pm_data[7:0] == $past(ee_data[15:8])) else $error("port 3 data wrong");
    chk_p4_caps: assert property (ld && ee_addr == 8'h58 |=>
        {pm_pme_support[3:2], pm_d2_support[1], pm_d1_support[1], pm_aux_current[5:3],
        pm_no_soft_reset[1]} == $past(ee_data[7:0])) else $error("port 4 caps wrong");
    chk_p5_caps: assert property (ld && ee_addr == 8'h5a |=>
        {pm_pme_support[5:4], pm_d2_support[2], pm_d1_support[2], pm_aux_current[8:6],
        pm_no_soft_reset[2]} == $past(ee_data[7:0])) else $error("port 5 caps wrong");
    chk_p5_data: assert property (ld && ee_addr == 8'h5b |=>
        pm_data[23:16] == $past(ee_data[15:8])) else $error("port 5 data wrong");
    chk_p0_slot: assert property (ld && ee_addr == 8'h60 |=>
        {pc_vc0_map[6:0], pc_port_num[2:0], pc_lpvc[0], pc_dsi[0], pc_slot_clock[0]}
        == {$past(ee_data[15:9]), $past(ee_data[6:1])}) else $error("port 0 wrong");
    chk_p0_no_impl: assert property (ee_req && ee_valid && ee_addr == 8'h60 |=>
        $stable(pc1_slot_impl)) else $error("port 0 word touched slot flag");
    chk_p1_slot: assert property (ld && ee_addr == 8'h62 |=>
        {pc_vc0_map[13:7], pc_port_num[5:3], pc_lpvc[1], pc_dsi[1], pc_slot_clock[1],
        pc1_slot_impl} == {$past(ee_data[15:9]), $past(ee_data[6:0])})
        else $error("port 1 wrong");
    chk_cfg_gate: assert property (cfg_ready |-> !ee_req)
        else $error("config open while loading");
    chk_ce_freeze: assert property (!ce |=> $stable(ee_req) && $stable(ee_addr) &&
        $stable(cfg_ready) && $stable(pm_data) && $stable(pc_vc0_map))
        else $error("state moved while clock enable low");
endmodule // epl_loader_chk
bind epl_loader epl_loader_chk u_chk (.*);

// ===== epl_loader_tb.sv
/*
 * Self-checking bench for the port configuration loader.
 * Assumes the store model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
module epl_loader_tb;
    reg         mclk, rst, psel, penable, pwrite, se, ce;
    reg  [31:0] cer;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd, rnd;
    reg  [15:0] ew [0:7];
    reg  [15:0] wd;
    reg  [7:0]  err_addr;
    reg  [3:0]  slow;
    integer     err_count, samples_checked, r, i, n;
    wire        ee_req, ee_valid, ee_err, pready, pslverr, cfg_ready, p1i;
    wire [7:0]  ee_addr;
    wire [15:0] ee_data;
    wire [31:0] prdata;
    wire [2:0]  nsr, d1, d2;
    wire [8:0]  aux;
    wire [5:0]  pme, pnum;
    wire [23:0] pmd;
    wire [1:0]  sclk, dsi, lpvc;
    wire [13:0] vc0;
    localparam [63:0] ADRS = 64'h5657_5859_5a5b_6062;
    epl_loader DUT (.mclk(mclk), .rst(rst), .ce(ce), .ee_req(ee_req), .ee_addr(ee_addr),
        .ee_valid(ee_valid), .ee_err(ee_err), .ee_data(ee_data), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .cfg_ready(cfg_ready), .pm_no_soft_reset(nsr),
        .pm_aux_current(aux), .pm_d1_support(d1), .pm_d2_support(d2), .pm_pme_support(pme),
        .pm_data(pmd), .pc_slot_clock(sclk), .pc_dsi(dsi), .pc_lpvc(lpvc),
        .pc_port_num(pnum), .pc_vc0_map(vc0), .pc1_slot_impl(p1i));
    epl_eeprom_model eem (.mclk(mclk), .rst(rst), .ee_req(ee_req), .ee_addr(ee_addr),
        .slow(slow), .err_addr(err_addr), .ee_valid(ee_valid), .ee_err(ee_err),
        .ee_data(ee_data));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp); begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end endtask
    task apb(input w, input [11:0] a, input [31:0] d); begin
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n = n + 1; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n == 20) chk(0, 1);
    end endtask
    // Bounded wait; a stuck level shows as a mismatch
    task wcfg(input v); begin
        n = 0;
        while (cfg_ready !== v && n < 400) begin @(posedge mclk); n = n + 1; end
        chk(cfg_ready, v);
    end endtask
    task give_verdict; begin
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    end endtask
    initial begin mclk = 1'b0; forever #2.5 mclk = ~mclk; end
    // Clock enable drops about one cycle in eight to exercise the freeze
    initial begin ce = 1'b1; cer = 32'h828a_99f1; end
    always @(posedge mclk) begin
        cer <= lfsr(cer);
        ce  <= (cer[2:0] != 3'h0);
    end
    initial begin #100000; err_count = err_count + 1; give_verdict; end
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; err_count = 0; samples_checked = 0; rnd = 32'h828a_99f1;
        for (r = 0; r < 4; r = r + 1) begin
            // Last round corrupts the port 3 data word
            err_addr = (r == 3) ? 8'h57 : 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                rnd = lfsr(rnd);
                wd = (r == 0) ? 16'hffff : (r == 1) ? 16'h0000 : rnd[15:0];
                eem.mem[ADRS[63-8*i -: 8]] = wd;
                if (ADRS[63-8*i -: 8] !== err_addr) ew[i] = wd;
            end
            slow = rnd[19:16];
            if (r == 0) begin repeat (5) @(posedge mclk); rst <= 1'b0; end
            else apb(1'b1, 12'h000, 32'h0000_0003);
            wcfg(1'b0);
            wcfg(1'b1);
            for (i = 0; i < 3; i = i + 1)
                chk({pmd[8*i +: 8], pme[2*i +: 2], d2[i], d1[i], aux[3*i +: 3], nsr[i]},
                    {ew[2*i+1][15:8], ew[2*i][7:0]});
            for (i = 0; i < 2; i = i + 1)
                chk({vc0[7*i +: 7], pnum[3*i +: 3], lpvc[i], dsi[i], sclk[i]},
                    {ew[6+i][15:9], ew[6+i][6:1]});
            chk(p1i, ew[7][0]);
            apb(1'b0, 12'h004, 32'h0000_0000);
            chk(rd[2:0], {r == 3, 2'b01});
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk(rd, {16'h0000, ew[7]});
        end
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk({se, rd[30:0]}, 32'h8000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        give_verdict;
    end
endmodule // epl_loader_tb
